// file: logic/tsw_frame_timer.sv
/*
 * Frame timer: bit-rate enable from a phase accumulator and the bit and
 * channel counters of the serial frame.
 * Assumes the 20 MHz clock; no frame pulse input, the frame free-runs.
 */
`timescale 1ns/1ns
module tsw_frame_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic step_o,
    output logic [2:0] bit_o,
    output logic [4:0] ch_o,
    output logic frame_o
);
    import tsw_pkg::*;

    logic [ACC_W-1:0] acc;
    logic [ACC_W:0] sum;
    logic tick;

    // Fractional divider keeps the exact average bit rate, jitter one clock
    assign sum = {1'b0, acc} + {1'b0, ACC_STEP};
    assign tick = (sum >= {1'b0, ACC_WRAP});

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc <= ACC_RESET;
        end else if (tick) begin
            acc <= ACC_W'(sum - {1'b0, ACC_WRAP});
        end else begin
            acc <= sum[ACC_W-1:0];
        end
    end

    // Bits run 7 down to 0 within a channel; reset loads bit 7, channel 0
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_o <= BIT_FIRST;
            ch_o <= CH_FIRST;
        end else if (tick) begin
            bit_o <= bit_o - 3'h1;
            if (bit_o == BIT_LAST) begin
                ch_o <= ch_o + 5'h01;
            end
        end
    end

    // Step marks the first cycle of each new bit position
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_o <= 1'b0;
        end else begin
            step_o <= tick;
        end
    end

    assign frame_o = step_o && (bit_o == BIT_FIRST) && (ch_o == CH_FIRST);
endmodule : tsw_frame_timer

// file: logic/tsw_output_control.sv
/*
 * Time-slot switch output control: control register, connection memories,
 * a small receive data memory, transmit streams with three-state control
 * and the per-channel control output stream.
 * Assumes an 8-bit non-multiplexed host port whose pins are asynchronous
 * to clk_i; the host holds address and data steady while strobed.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - Forcing bit sends low connection memory everywhere
// - Forcing treats source and drive bits set
// - Otherwise stored source and drive bits act
// - Source bit one sends byte, zero switches
// - Switched byte: stream upper three, channel lower
// - Drive enable low holds all stream outputs high-Z
// - Drive enable high: per-channel drive bit decides
// - All 256 control bits sent each frame
// - Control bits lead their channel by one
// - Channel 1 streams 0-7 during channel 0
// - Reset floats outputs, clears registers, counters to bit 7, channel 0
// - Drive enable changes only three-state, nothing else
// - Control at A5,A1,A0 low; A5 high channels
// - Split: reads data memory, writes connection memory
// - Memory select decodes none, data, low, high
// - Stream field picks the 32-channel subsection
module tsw_output_control (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic output_drive_enable_i,
    input wire logic [tsw_pkg::STREAMS-1:0] rx_i,
    output logic [tsw_pkg::STREAMS-1:0] tx_o,
    output logic [tsw_pkg::STREAMS-1:0] tx_oe_o,
    output logic per_channel_control_output_o,
    output logic frame_o,
    input wire logic cs_n_i,
    input wire logic ds_i,
    input wire logic rw_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic dta_n_o
);
    import tsw_pkg::*;

    logic [7:0] switch_control;
    logic [7:0] connection_memory_low [LOCATIONS];
    logic [7:0] connection_memory_high [LOCATIONS];
    logic [7:0] data_memory [LOCATIONS];
    logic [STREAMS-1:0] rx_s1, rx_s2, rx_s3;
    logic [2:0] drv_en_s, stb_s;
    logic drv_en_q, stb_q, stb_prev;
    logic step;
    logic [2:0] bit_pos;
    logic [4:0] ch_pos;
    logic [7:0] tx_sr [STREAMS];
    logic [7:0] rx_sr [STREAMS];
    logic [STREAMS-1:0] drive_q;
    logic processor_forcing_bit;
    logic split_access_bit;
    logic [1:0] memory_select_field;
    logic [2:0] stream_select_field;
    logic access;
    logic [7:0] host_index;

    assign processor_forcing_bit = switch_control[CTRL_FORCE];
    assign split_access_bit = switch_control[CTRL_SPLIT];
    assign memory_select_field = switch_control[CTRL_MS_HI:CTRL_MS_LO];
    assign stream_select_field = switch_control[CTRL_ST_HI:CTRL_ST_LO];

    // Location index from stream and channel, used by every port
    function automatic logic [7:0] loc(input logic [2:0] s,
                                       input logic [4:0] c);
        return {s, c};
    endfunction : loc

    tsw_frame_timer u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .step_o(step),
        .bit_o(bit_pos),
        .ch_o(ch_pos),
        .frame_o(frame_o)
    );

    // Pin synchronisers; strobe and drive enable count once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_en_s <= 3'h0;
            stb_s <= 3'h0;
            rx_s1 <= '0;
            rx_s2 <= '0;
            rx_s3 <= '0;
        end else begin
            drv_en_s <= {drv_en_s[1:0], output_drive_enable_i};
            stb_s <= {stb_s[1:0], ~cs_n_i & ds_i};
            rx_s1 <= rx_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    // Settled levels; drive enable feeds only three-state gating
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_en_q <= 1'b0;
            stb_q <= 1'b0;
            stb_prev <= 1'b0;
        end else begin
            if (drv_en_s[1] == drv_en_s[2]) begin
                drv_en_q <= drv_en_s[2];
            end
            if (stb_s[1] == stb_s[2]) begin
                stb_q <= stb_s[2];
            end
            stb_prev <= stb_q;
        end
    end

    assign access = stb_q & ~stb_prev;
    assign host_index = loc(stream_select_field, addr_i[4:0]);

    // Control register; reset clears it, bit 5 is never stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            switch_control <= CTRL_RESET;
        end else if (access && !rw_i && !addr_i[ADDR_MEM]
                     && addr_i[1:0] == 2'h0) begin
            switch_control <= data_i & CTRL_MASK;
        end
    end

    // Host writes to connection memory; data memory takes none
    always_ff @(posedge clk_i) begin
        if (access && !rw_i && addr_i[ADDR_MEM]) begin
            if (memory_select_field == MS_CONN_LOW) begin
                connection_memory_low[host_index] <= data_i;
            end else if (memory_select_field == MS_CONN_HIGH) begin
                connection_memory_high[host_index] <= data_i;
            end
        end
    end

    // Host reads; split mode sends every memory read to data memory
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= READ_IDLE;
        end else if (access && rw_i) begin
            if (!addr_i[ADDR_MEM]) begin
                data_o <= (addr_i[1:0] == 2'h0) ? switch_control
                                                : READ_IDLE;
            end else if (split_access_bit) begin
                data_o <= data_memory[host_index];
            end else begin
                case (memory_select_field)
                    MS_DATA: data_o <= data_memory[host_index];
                    MS_CONN_LOW: data_o <= connection_memory_low[host_index];
                    MS_CONN_HIGH: data_o <= connection_memory_high[host_index];
                    default: data_o <= READ_IDLE;
                endcase
            end
        end
    end

    // Acknowledge and bus drive follow the settled strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dta_n_o <= 1'b1;
            data_oe_o <= 1'b0;
        end else begin
            dta_n_o <= ~(stb_q & stb_prev);
            data_oe_o <= stb_q & stb_prev & rw_i;
        end
    end

    // Receive shift registers fill data memory at each channel end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < STREAMS; s++) begin
                rx_sr[s] <= 8'h00;
            end
        end else if (step) begin
            for (int s = 0; s < STREAMS; s++) begin
                rx_sr[s] <= {rx_sr[s][6:0], rx_s3[s]};
            end
        end
    end

    // Memory contents are not reset, so they start undefined
    always_ff @(posedge clk_i) begin
        if (step && bit_pos == BIT_FIRST) begin
            for (int s = 0; s < STREAMS; s++) begin
                data_memory[loc(3'(s), ch_pos - 5'h01)] <= rx_sr[s];
            end
        end
    end

    // Transmit: load each stream at channel start, then shift MSB first
    generate
        for (genvar g = 0; g < STREAMS; g++) begin : g_tx
            logic [7:0] low_byte;
            logic [7:0] high_byte;
            logic send_byte;
            assign low_byte = connection_memory_low[loc(3'(g), ch_pos)];
            assign high_byte = connection_memory_high[loc(3'(g), ch_pos)];
            // Forcing overrides the stored source bit
            assign send_byte = processor_forcing_bit
                             | high_byte[HIGH_SOURCE];

            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    tx_sr[g] <= 8'h00;
                    drive_q[g] <= 1'b0;
                end else if (step && bit_pos == BIT_FIRST) begin
                    // Byte itself, or source stream and channel in it
                    tx_sr[g] <= send_byte ? low_byte
                        : data_memory[loc(low_byte[7:5],
                                          low_byte[4:0])];
                    drive_q[g] <= processor_forcing_bit
                                | high_byte[HIGH_DRIVE];
                end else if (step) begin
                    tx_sr[g] <= {tx_sr[g][6:0], 1'b0};
                end
            end

            assign tx_o[g] = tx_sr[g][7];
            // Master enable overrides every channel's drive bit
            assign tx_oe_o[g] = drv_en_q & drive_q[g];
        end
    endgenerate

    // Control bit location: one channel ahead, stream 7 minus bit position
    logic [7:0] ctrl_loc;
    assign ctrl_loc = loc(3'h7 - bit_pos, ch_pos + 5'h01);

    // Control output: bit 7..0 carry streams 0..7 of the next channel
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_channel_control_output_o <= 1'b0;
        end else if (step) begin
            per_channel_control_output_o <=
                connection_memory_high[ctrl_loc][HIGH_CTRL_OUT];
        end
    end
endmodule : tsw_output_control

// file: logic/tsw_pkg.sv
/*
 * Constants shared by the time-slot switch output control block: timing,
 * control register layout, connection memory high layout, memory codes.
 * Assumes a single 20 MHz system clock; all frame timing derives from it.
 */
package tsw_pkg;
    // System clock and serial line rate, in kHz to keep the ratio exact
    localparam int CLK_KHZ = 20000;
    localparam int BIT_KHZ = 2048;
    localparam int ACC_W = 15;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);
    localparam logic [ACC_W-1:0] ACC_RESET = 15'h0000;

    // Frame geometry
    localparam int STREAMS = 8;
    localparam int CHANNELS = 32;
    localparam int LOCATIONS = STREAMS * CHANNELS;
    localparam logic [2:0] BIT_FIRST = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h0;
    localparam logic [4:0] CH_FIRST = 5'h00;

    // Control register fields
    localparam int CTRL_SPLIT = 7;
    localparam int CTRL_FORCE = 6;
    localparam int CTRL_MS_HI = 4;
    localparam int CTRL_MS_LO = 3;
    localparam int CTRL_ST_HI = 2;
    localparam int CTRL_ST_LO = 0;
    localparam logic [7:0] CTRL_MASK = 8'hDF;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Memory select codes
    localparam logic [1:0] MS_NONE = 2'h0;
    localparam logic [1:0] MS_DATA = 2'h1;
    localparam logic [1:0] MS_CONN_LOW = 2'h2;
    localparam logic [1:0] MS_CONN_HIGH = 2'h3;

    // Connection memory high bits
    localparam int HIGH_SOURCE = 2;
    localparam int HIGH_CTRL_OUT = 1;
    localparam int HIGH_DRIVE = 0;

    // Host address decode
    localparam int ADDR_MEM = 5;
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage : tsw_pkg

// file: test/tsw_host_model.sv
/* Host processor model on the 8-bit parallel port.
   Assumes the bench calls acc; hung_o flags an unanswered access. */
`timescale 1ns/1ns
module tsw_host_model (
    input wire logic clk_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i,
    input wire logic dta_n_i,
    output logic cs_n_o,
    output logic ds_o,
    output logic rw_o,
    output logic [5:0] addr_o,
    output logic [7:0] wdata_o,
    output logic hung_o
);
    initial begin
        cs_n_o = 1'b1;
        ds_o = 1'b0;
        rw_o = 1'b1;
        addr_o = 6'h00;
        wdata_o = 8'h00;
        hung_o = 1'b0;
    end
    // One strobed access, held until acknowledge is seen
    task automatic acc(input logic rd, input logic [5:0] a,
                       input logic [7:0] w, output logic [7:0] r);
        int n;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        ds_o <= 1'b1;
        rw_o <= rd;
        addr_o <= a;
        wdata_o <= w;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (dta_n_i !== 1'b0 && n < 40);
        r = data_oe_i ? data_i : 8'hZZ;
        if (n >= 40) hung_o <= 1'b1;
        cs_n_o <= 1'b1;
        ds_o <= 1'b0;
        addr_o <= ~a; // Released lines keep no stale value
        wdata_o <= ~w;
        n = 0;
        while (dta_n_i !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) hung_o <= 1'b1;
    endtask : acc
endmodule : tsw_host_model

// file: test/tsw_oc_assertions.sv
/* Port checker for the output control block: host acknowledge,
   three-state and frame marker timing.
   Assumes a bind onto tsw_output_control from the bench top. */
`timescale 1ns/1ns
module tsw_oc_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic output_drive_enable_i,
    input wire logic [tsw_pkg::STREAMS-1:0] tx_oe_o,
    input wire logic frame_o,
    input wire logic cs_n_i,
    input wire logic ds_i,
    input wire logic rw_i,
    input wire logic data_oe_o,
    input wire logic dta_n_o
);
    import tsw_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Pin strobe as the host presents it
    wire logic strb = !cs_n_i && ds_i;
    // Strobe released long enough for the synchroniser to settle
    sequence s_quiet;
        !strb [*6];
    endsequence
    sequence s_ack_start;
        $fell(dta_n_o);
    endsequence
    // Acknowledge edge qualified by the direction of the access
    sequence s_read_ack;
        $fell(dta_n_o) && rw_i;
    endsequence
    sequence s_write_ack;
        $fell(dta_n_o) && !rw_i;
    endsequence
    a_ack_in_time: assert property (
        $rose(strb) |-> ##[2:8] !dta_n_o)
        else $error("acknowledge late");
    a_ack_stands: assert property (
        s_ack_start |=> !dta_n_o [*2])
        else $error("acknowledge too short");
    a_ack_release: assert property (
        s_quiet |-> dta_n_o)
        else $error("acknowledge held");
    a_read_drives: assert property (
        s_read_ack |-> data_oe_o)
        else $error("read not driven");
    a_write_quiet: assert property (
        s_write_ack |-> !data_oe_o)
        else $error("write drives bus");
    a_oe_with_ack: assert property (
        data_oe_o |-> !dta_n_o)
        else $error("bus driven without acknowledge");
    a_float_when_off: assert property (
        !output_drive_enable_i [*5] |-> tx_oe_o == '0)
        else $error("output driven with enable low");
    a_reset_float: assert property (
        $rose(rst_n_i) |-> tx_oe_o == '0 && dta_n_o && !data_oe_o)
        else $error("outputs not idle after reset");
    a_frame_single: assert property (
        frame_o |=> !frame_o [*8])
        else $error("frame marker too long");
endmodule : tsw_oc_assertions

// file: test/tsw_output_control_tb_top.sv
/* Self-checking bench for the output control block.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ns
module tsw_output_control_tb_top;
    import tsw_pkg::*;
    // Only streams 3 and 5 idle high, so a wrong source stream shows
    localparam logic [7:0] RX = 8'h28;
    localparam logic [7:0] CTRL_MAP = 8'hA6;
    localparam int FRAME_CLKS = (LOCATIONS * CLK_KHZ) / BIT_KHZ;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic drive_en = 1'b0; // Held low until programmed
    logic cs_n, ds, rw, hung, data_oe, dta_n, ctrl_out, frame;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, tx, tx_oe, txb, oeb, ccb;
    int n_errors = 0;
    int num_checks = 0;
    always #25 clk_i = ~clk_i;
    tsw_output_control DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .output_drive_enable_i(drive_en), .rx_i(RX), .tx_o(tx),
        .tx_oe_o(tx_oe), .per_channel_control_output_o(ctrl_out),
        .frame_o(frame), .cs_n_i(cs_n), .ds_i(ds), .rw_i(rw),
        .addr_i(addr), .data_i(wdata), .data_o(rdata),
        .data_oe_o(data_oe), .dta_n_o(dta_n));
    tsw_host_model HOST (.clk_i(clk_i), .data_i(rdata),
        .data_oe_i(data_oe), .dta_n_i(dta_n), .cs_n_o(cs_n), .ds_o(ds),
        .rw_o(rw), .addr_o(addr), .wdata_o(wdata), .hung_o(hung));
    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // Unanswered host access ends the run
    always @(posedge hung) begin
        n_errors++;
        give_verdict();
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] w);
        logic [7:0] r;
        HOST.acc(1'b0, a, w, r);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] r);
        HOST.acc(1'b1, a, 8'h00, r);
    endtask : rd
    // Mid-bit capture of stream 0 and control output in channel ch
    task automatic grab(input int ch);
        int n, k;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (frame !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            n_errors++;
            give_verdict();
        end
        k = 0;
        for (int i = 0; i < 8; i++) begin
            while (k < ((ch * 8 + i) * CLK_KHZ) / BIT_KHZ + 4) begin
                @(posedge clk_i);
                k++;
            end
            @(negedge clk_i);
            txb[7-i] = tx[0];
            oeb[7-i] = tx_oe[0];
            ccb[7-i] = ctrl_out;
        end
    endtask : grab
    task automatic t_reset();
        logic [7:0] r;
        chk(tx_oe, 8'h00);
        rd(6'h00, r);
        chk(r, CTRL_RESET);
        wr(6'h00, 8'hFF);
        rd(6'h00, r);
        chk(r, CTRL_MASK);
        wr(6'h01, 8'h00);
        rd(6'h1C, r);
        chk(r, CTRL_MASK);
    endtask : t_reset
    task automatic t_ctrl_out();
        logic [7:0] e;
        for (int s = 0; s < 8; s++) begin
            wr(6'h00, 8'h18 | 8'(s));
            wr(6'h21, {6'h00, CTRL_MAP[s], 1'b0});
            e[7-s] = CTRL_MAP[s];
        end
        wr(6'h00, 8'h18);
        wr(6'h22, 8'h00);
        wr(6'h00, 8'h10);
        wr(6'h22, 8'hC3);
        drive_en <= 1'b1; // Paths programmed first
        grab(0);
        chk(ccb, e);
        grab(2);
        chk(oeb, 8'h00);
    endtask : t_ctrl_out
    task automatic t_force();
        logic [7:0] r;
        wr(6'h00, 8'h40);
        grab(2);
        chk(txb, 8'hC3);
        chk(oeb, 8'hFF);
        @(posedge clk_i);
        chk(tx_oe, 8'hFF);
        drive_en <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk(tx_oe, 8'h00);
        rd(6'h00, r);
        chk(r, 8'h40);
    endtask : t_force
    task automatic t_switch();
        wr(6'h00, 8'h18);
        wr(6'h22, 8'h01);
        wr(6'h00, 8'h10);
        wr(6'h22, 8'hA0);
        drive_en <= 1'b1;
        grab(2);
        chk(txb, {8{RX[5]}});
        chk(oeb, 8'hFF);
    endtask : t_switch
    task automatic t_split();
        logic [7:0] r;
        wr(6'h00, 8'h93);
        wr(6'h22, 8'h55);
        rd(6'h22, r);
        chk(r, {8{RX[3]}});
        wr(6'h00, 8'h0B);
        wr(6'h22, 8'h77);
        wr(6'h00, 8'h13);
        rd(6'h22, r);
        chk(r, 8'h55);
        wr(6'h00, 8'h10);
        rd(6'h22, r);
        chk(r, 8'hA0);
    endtask : t_split
    // Mid-run reset with drive on: floats, clears, restarts the frame
    task automatic t_restart();
        logic [7:0] r;
        int n;
        logic ok;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(tx_oe, 8'h00);
        chk({7'h00, ctrl_out}, 8'h00);
        rst_n_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (frame !== 1'b1 && n < 3000);
        ok = (n >= FRAME_CLKS - 8) && (n <= FRAME_CLKS + 8);
        chk({7'h00, ok}, 8'h01);
        if (n >= 3000) begin
            give_verdict();
        end
        rd(6'h00, r);
        chk(r, CTRL_RESET);
    endtask : t_restart
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_ctrl_out();
        t_force();
        t_switch();
        t_split();
        t_restart();
        give_verdict();
    end
endmodule : tsw_output_control_tb_top
bind tsw_output_control tsw_oc_assertions CHK (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .output_drive_enable_i(output_drive_enable_i),
    .tx_oe_o(tx_oe_o), .frame_o(frame_o), .cs_n_i(cs_n_i), .ds_i(ds_i),
    .rw_i(rw_i), .data_oe_o(data_oe_o), .dta_n_o(dta_n_o));
